// file: src/hfs_supervisor.sv
// Purpose: Digital fault supervisor of an isolated buck converter: hiccup, discharge, power-good delay.
// Assumes: mclk at 50 MHz; a switching cycle is one enable pulse from a divider; comparators are asynchronous.
// Notes: Comparator inputs are synchronised, so every reaction lags its pin by at least two mclk cycles.
`timescale 1ns/100ps
`include "hfs_defines.svh"
module hfs_supervisor (
    input  wire logic               mclk,
    input  wire logic               rst_n,
    input  wire logic               enable_undervoltage_input,
    input  wire logic               runaway_limit,
    input  wire logic               peak_limit,
    input  wire logic               sink_limit,
    input  wire logic               discharge_limit,
    input  wire logic               primary_uv,
    input  wire logic               pgood_above_rise,
    input  wire logic               pgood_below_fall,
    input  wire logic               overtemp,
    input  wire logic               softstart_done,
    input  wire logic               pwm_on,
    output logic                    high_side_switch,
    output logic                    low_side_switch,
    output logic                    softstart_clear,
    output logic                    power_good_o,
    output logic                    power_good_oe_n,
    output hfs_pkg::hfs_state_t     state_o
);
    import hfs_pkg::*;

    logic [10:0] sync_q;
    logic        en_s;
    logic        run_s;
    logic        pk_s;
    logic        sk_s;
    logic        dis_s;
    logic        uv_s;
    logic        rise_s;
    logic        fall_s;
    logic        ot_s;
    logic        ssd_s;
    logic        pwm_s;

    hfs_sync #(.W(11)) u_sync (
        .mclk  (mclk),
        .rst_n (rst_n),
        .d     ({enable_undervoltage_input, runaway_limit, peak_limit, sink_limit, discharge_limit,
                 primary_uv, pgood_above_rise, pgood_below_fall, overtemp, softstart_done, pwm_on}),
        .q     (sync_q)
    );
    assign {en_s, run_s, pk_s, sk_s, dis_s, uv_s, rise_s, fall_s, ot_s, ssd_s, pwm_s} = sync_q;

    // Switching-cycle enable; the analog side sees cycles at mclk / divider.
    logic [7:0] div_reg;
    logic       sw_tick;
    assign sw_tick = (div_reg == `HFS_SW_DIV - 8'h01);
    always_ff @(posedge mclk) begin
        if (!rst_n || !en_s) begin
            div_reg <= 8'h00;
        end else if (sw_tick) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    hfs_state_t  state_reg;
    hfs_state_t  state_next;
    logic [4:0]  neg_cnt_reg;
    logic [15:0] hic_cnt_reg;
    logic        sink_seen_reg;
    logic        pk_trip_reg;
    logic        ls_trip_reg;
    logic        trigger;
    logic        hic_done;

    assign hic_done = sw_tick && (hic_cnt_reg == `HFS_HICCUP_CYCLES - 16'h0001);
    // Runaway and the sink count are armed in soft-start too, so a retry that faults again goes back to hiccup; undervoltage acts in run only.
    assign trigger = run_s
                  || (neg_cnt_reg == `HFS_NEG_EVENTS)
                  || (uv_s && state_reg == HFS_RUN);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            HFS_OFF:       state_next = HFS_SOFTSTART;
            HFS_SOFTSTART: begin
                if (trigger) begin
                    state_next = HFS_HICCUP;
                end else if (ssd_s) begin
                    state_next = HFS_RUN;
                end
            end
            HFS_RUN:       if (trigger) state_next = HFS_HICCUP;
            HFS_HICCUP:    if (hic_done) state_next = HFS_SOFTSTART;
            HFS_THERMAL:   if (!ot_s) state_next = HFS_SOFTSTART;
        endcase
        if (ot_s) begin
            state_next = HFS_THERMAL;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !en_s) begin
            state_reg <= HFS_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n || !en_s || state_reg != HFS_HICCUP) begin
            hic_cnt_reg <= 16'h0000;
        end else if (sw_tick) begin
            hic_cnt_reg <= hic_cnt_reg + 16'h0001;
        end
    end

    // Consecutive sink-limit cycles; one clean cycle starts the count over.
    always_ff @(posedge mclk) begin
        if (!rst_n || !en_s || state_reg == HFS_HICCUP || state_reg == HFS_OFF || state_reg == HFS_THERMAL) begin
            neg_cnt_reg   <= 5'h00;
            sink_seen_reg <= 1'b0;
        end else if (sw_tick) begin
            sink_seen_reg <= 1'b0;
            if (sink_seen_reg || sk_s) begin
                neg_cnt_reg <= (neg_cnt_reg == `HFS_NEG_EVENTS) ? neg_cnt_reg : neg_cnt_reg + 5'h01;
            end else begin
                neg_cnt_reg <= 5'h00;
            end
        end else if (sk_s) begin
            sink_seen_reg <= 1'b1;
        end
    end

    // Per-cycle latches; the limits hold their switch off until the next cycle starts.
    always_ff @(posedge mclk) begin
        if (!rst_n || !en_s || sw_tick) begin
            pk_trip_reg <= 1'b0;
            ls_trip_reg <= 1'b0;
        end else begin
            if (pk_s) pk_trip_reg <= 1'b1;
            if (state_reg == HFS_HICCUP ? dis_s : sk_s) ls_trip_reg <= 1'b1;
        end
    end

    logic switching;
    assign switching = (state_reg == HFS_SOFTSTART) || (state_reg == HFS_RUN);
    always_ff @(posedge mclk) begin
        if (!rst_n || !en_s) begin
            high_side_switch <= 1'b0;
            low_side_switch  <= 1'b0;
        end else if (state_reg == HFS_HICCUP) begin
            high_side_switch <= 1'b0;
            low_side_switch  <= !ls_trip_reg && !dis_s && !sw_tick;
        end else if (switching) begin
            high_side_switch <= pwm_s && !pk_trip_reg && !pk_s;
            low_side_switch  <= !pwm_s && !ls_trip_reg && !sk_s;
        end else begin
            high_side_switch <= 1'b0;
            low_side_switch  <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            softstart_clear <= 1'b1;
        end else begin
            softstart_clear <= !en_s || state_next != HFS_SOFTSTART && state_next != HFS_RUN;
        end
    end

    // Power-good delay; outside enable the pin is held low, which is one valid choice.
    logic [10:0] pg_cnt_reg;
    logic        pg_rel_reg;
    always_ff @(posedge mclk) begin
        if (!rst_n || !en_s || fall_s || ot_s) begin
            pg_cnt_reg <= 11'h000;
            pg_rel_reg <= 1'b0;
        end else if (!rise_s) begin
            pg_cnt_reg <= 11'h000;
        end else if (pg_cnt_reg == `HFS_PGOOD_CYCLES) begin
            pg_rel_reg <= 1'b1;
        end else if (sw_tick) begin
            pg_cnt_reg <= pg_cnt_reg + 11'h001;
        end
    end
    assign power_good_o    = 1'b0;
    assign power_good_oe_n = pg_rel_reg;
    assign state_o         = state_reg;

    sequence s_hiccup_entry;
        state_reg != HFS_HICCUP ##1 state_reg == HFS_HICCUP;
    endsequence
    a_runaway_hiccup: assert property (@(posedge mclk) disable iff (!rst_n)
        run_s && en_s && !ot_s && switching |=> state_reg == HFS_HICCUP) else $error("runaway missed");
    a_neg_count_hic: assert property (@(posedge mclk) disable iff (!rst_n)
        neg_cnt_reg == `HFS_NEG_EVENTS && en_s && !ot_s && switching |=> state_reg == HFS_HICCUP)
        else $error("sixteen sink events missed");
    a_uv_softstart: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == HFS_SOFTSTART && uv_s && !run_s && !ssd_s && !ot_s && en_s && neg_cnt_reg != `HFS_NEG_EVENTS
        |=> state_reg == HFS_SOFTSTART) else $error("uv acted in soft-start");
    a_hiccup_hs_off: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == HFS_HICCUP ##1 state_reg == HFS_HICCUP |-> !high_side_switch) else $error("hs on in hiccup");
    a_hiccup_exit: assert property (@(posedge mclk) disable iff (!rst_n)
        hic_done && en_s && !ot_s |=> state_reg == HFS_SOFTSTART) else $error("no restart");
    a_hiccup_length: assert property (@(posedge mclk) disable iff (!rst_n)
        s_hiccup_entry |-> hic_cnt_reg == 16'h0000) else $error("timeout not cleared");
    a_pg_fall_low: assert property (@(posedge mclk) disable iff (!rst_n)
        fall_s |=> !power_good_oe_n && pg_cnt_reg == 11'h000) else $error("pgood not low");
    a_pg_thermal: assert property (@(posedge mclk) disable iff (!rst_n)
        ot_s |=> !power_good_oe_n) else $error("pgood high in thermal");
    a_disable_off: assert property (@(posedge mclk) disable iff (!rst_n)
        !en_s |=> !high_side_switch && !low_side_switch && softstart_clear) else $error("switch on when disabled");
    a_peak_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        pk_s && !sw_tick |=> !high_side_switch) else $error("hs on after peak trip");
    // Only the full timeout, thermal shutdown or disable may end a hiccup.
    a_hiccup_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        state_reg == HFS_HICCUP && !hic_done && en_s && !ot_s |=> state_reg == HFS_HICCUP)
        else $error("hiccup left before timeout");
endmodule

// file: src/hfs_defines.svh
// Purpose: Named constants for the hiccup fault supervisor.
// Assumes: One switching-rate clock enable derived from mclk.
// Notes: Counts are in switching cycles, except HFS_SW_DIV, which is in mclk cycles.
`ifndef HFS_DEFINES_SVH
`define HFS_DEFINES_SVH
`define HFS_NEG_EVENTS      5'h10
`define HFS_HICCUP_CYCLES   16'h8000
`define HFS_PGOOD_CYCLES    11'h400
`define HFS_SW_DIV          8'h32
`endif

// file: src/hfs_pkg.sv
// Purpose: Types for the hiccup fault supervisor.
// Assumes: Nothing beyond the defines header.
// Notes: The state enum is shared with the assertion code.
package hfs_pkg;
    typedef enum logic [2:0] {
        HFS_OFF,
        HFS_SOFTSTART,
        HFS_RUN,
        HFS_HICCUP,
        HFS_THERMAL
    } hfs_state_t;
endpackage

// file: src/hfs_sync.sv
// Purpose: Two-flop synchroniser for each asynchronous comparator input.
// Assumes: Inputs are slow levels from analog comparators.
// Notes: First stage is read only by the second stage.
`timescale 1ns/100ps
module hfs_sync #(
    parameter int W = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    meta_reg[i] <= 1'b0;
                    q[i]        <= 1'b0;
                end else begin
                    meta_reg[i] <= d[i];
                    q[i]        <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule

// file: dv/hfs_partner.sv
// Purpose: Far-side model of the discharge comparator and the soft-start ramp.
// Assumes: Levels change just after mclk edges.
// Notes: Delays are small arbitrary counts, so the ramp ends well inside a run.
`timescale 1ns/100ps
module hfs_partner (
    input  wire logic mclk,
    input  wire logic low_side_switch,
    input  wire logic softstart_clear,
    output logic      discharge_limit,
    output logic      softstart_done
);
    logic [3:0] ls_cnt_reg;
    logic [5:0] ss_cnt_reg;
    // Negative current builds while the low side conducts.
    always_ff @(posedge mclk) begin
        ls_cnt_reg <= low_side_switch ? ls_cnt_reg + {3'h0, ~&ls_cnt_reg} : 4'h0;
    end
    // The ramp restarts whenever it is held in clear.
    always_ff @(posedge mclk) begin
        ss_cnt_reg <= softstart_clear ? 6'h00 : ss_cnt_reg + {5'h00, ~&ss_cnt_reg};
    end
    assign discharge_limit = ls_cnt_reg >= 4'h4;
    assign softstart_done  = ss_cnt_reg == 6'h3F;
endmodule

// file: dv/hfs_supervisor_tb.sv
// Purpose: Self-checking bench of the hiccup fault supervisor.
// Assumes: Hiccup expiry is too long to run, so only entry is checked.
// Notes: Each state or power-good change consumes one queued note.
`timescale 1ns/100ps
module hfs_supervisor_tb;
    import hfs_pkg::*;
    logic       mclk, rst_n, en, runaway, peak, sink, uv, rise, fall, otemp, pwm;
    logic       hs, ls, ss_clr, pg_o, pg_oe_n, dis, ss_done;
    hfs_state_t state;
    logic [3:0] notes[$];
    logic [3:0] prev = 4'h0;
    logic [31:0] lfsr_reg = 32'hED3567C2;
    int         n_fail, compares, cycles, lows;

    hfs_supervisor u_hfs_supervisor (.mclk(mclk), .rst_n(rst_n), .enable_undervoltage_input(en),
        .runaway_limit(runaway), .peak_limit(peak), .sink_limit(sink), .discharge_limit(dis),
        .primary_uv(uv), .pgood_above_rise(rise), .pgood_below_fall(fall), .overtemp(otemp),
        .softstart_done(ss_done), .pwm_on(pwm), .high_side_switch(hs), .low_side_switch(ls),
        .softstart_clear(ss_clr), .power_good_o(pg_o), .power_good_oe_n(pg_oe_n), .state_o(state));
    hfs_partner u_hfs_partner (.mclk(mclk), .low_side_switch(ls), .softstart_clear(ss_clr),
        .discharge_limit(dis), .softstart_done(ss_done));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic note(input logic oe, input hfs_state_t st);
        notes.push_back({oe, st});
    endtask
    task automatic drain(input int lim);
        for (int i = 0; i < lim && notes.size() != 0; i++) tick(1);
        chk(4'(notes.size()), 4'h0);
    endtask
    task automatic report_and_stop;
        $display("comparisons=%0d mismatches=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Random peak trips and PWM levels keep the switch logic busy throughout.
    always @(posedge mclk) begin
        lfsr_reg <= lfsr(lfsr_reg);
        peak     <= lfsr_reg[0];
        pwm      <= lfsr_reg[1];
    end
    always @(negedge mclk) begin
        if (rst_n && {pg_oe_n, state} !== prev) begin
            if (notes.size() == 0) chk({pg_oe_n, state}, prev);
            else chk({pg_oe_n, state}, notes.pop_front());
        end
        prev = {pg_oe_n, state};
    end
    // The ceiling sits well above the longest expected run.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            report_and_stop();
        end
    end

    initial begin
        {en, runaway, sink, uv, rise, fall, otemp, rst_n} = 8'h00;
        tick(6);
        rst_n <= 1'b1;
        en <= 1'b1;
        note(1'b0, HFS_SOFTSTART);
        drain(20);
        runaway <= 1'b1;
        note(1'b0, HFS_HICCUP);
        drain(10);
        runaway <= 1'b0;
        lows = 0;
        // Switch outputs are looked at mid-cycle, where they have settled.
        repeat (300) begin
            @(negedge mclk);
            chk({3'h0, hs}, 4'h0);
            lows += (ls === 1'b1) ? 1 : 0;
        end
        tick(1);
        chk({3'h0, lows > 20 && lows < 200}, 4'h1);
        en <= 1'b0;
        note(1'b0, HFS_OFF);
        drain(10);
        chk({1'b0, ls, hs, ss_clr}, 4'h1);
        $display("runaway test done");
        uv <= 1'b1;
        en <= 1'b1;
        note(1'b0, HFS_SOFTSTART);
        note(1'b0, HFS_RUN);
        note(1'b0, HFS_HICCUP);
        drain(300);
        en <= 1'b0;
        uv <= 1'b0;
        note(1'b0, HFS_OFF);
        drain(10);
        $display("undervoltage test done");
        en <= 1'b1;
        note(1'b0, HFS_SOFTSTART);
        note(1'b0, HFS_RUN);
        drain(300);
        rise <= 1'b1;
        tick(50000);
        note(1'b1, HFS_RUN);
        drain(2000);
        fall <= 1'b1;
        rise <= 1'b0;
        note(1'b0, HFS_RUN);
        drain(5);
        fall <= 1'b0;
        $display("power good test done");
        sink <= 1'b1;
        tick(700);
        sink <= 1'b0;
        tick(120);
        sink <= 1'b1;
        // Fourteen events at most fit in this wait, so a count left over from before would show here.
        tick(700);
        chk({1'b0, state}, {1'b0, HFS_RUN});
        note(1'b0, HFS_HICCUP);
        drain(200);
        sink <= 1'b0;
        en <= 1'b0;
        note(1'b0, HFS_OFF);
        drain(10);
        $display("sink event test done");
        en <= 1'b1;
        note(1'b0, HFS_SOFTSTART);
        note(1'b0, HFS_RUN);
        drain(300);
        otemp <= 1'b1;
        note(1'b0, HFS_THERMAL);
        drain(5);
        tick(20);
        chk({2'h0, hs, ls}, 4'h0);
        otemp <= 1'b0;
        note(1'b0, HFS_SOFTSTART);
        note(1'b0, HFS_RUN);
        drain(300);
        $display("thermal test done");
        report_and_stop();
    end
endmodule
